//--- pkg/slmt_pkg.sv
// Package of constants and types shared by both ends of the slow link.
package slmt_pkg;

    // ********************************************************************
    // Link geometry.
    // ********************************************************************

    localparam int LINE_W   = 16;               // Shared lines 31 to 16 carried as 16 bits.
    localparam int LOW_W    = 14;               // Shared lines 15 to 2 carried as 14 bits.
    localparam int BE_LSB   = 0;                // Byte enables sit in bits 3..0 of the word.
    localparam int WR_BIT   = 4;                // Write/read flag sits in bit 4 (line 20).
    localparam int TURN_CYC = 2;                // Turnaround clocks at the start of a frame.
    localparam logic [1:0] TURN_LAST = 2'h1;    // Count value of the final turnaround clock.

    // ********************************************************************
    // Slow-side sequencer states.
    // ********************************************************************

    typedef enum logic [2:0] {
        SLMT_IDLE, SLMT_HOLD, SLMT_TURN, SLMT_HIADR, SLMT_CMD,
        SLMT_LOADR, SLMT_DATA, SLMT_WAIT
    } slmt_state_e;

    // ********************************************************************
    // Fast-side responder states.
    // ********************************************************************

    typedef enum logic [2:0] {
        SLMT_F_IDLE, SLMT_F_TURN, SLMT_F_HIADR, SLMT_F_CMD,
        SLMT_F_LOADR, SLMT_F_DATA, SLMT_F_MEM, SLMT_F_DONE
    } slmt_fstate_e;

endpackage : slmt_pkg

//--- pkg/slmt_link_if.sv
// Interface joining the slow-side and fast-side ends of the link.
`timescale 1ns/1ps
interface slmt_link_if;

    logic        hold_req;             // Slow side asks for the link.
    logic        hold_ack;             // Fast-side arbiter grants the link.
    logic        slow_start_ready_strobe_b;  // Slow-side strobe, active low.
    logic        fast_start_ready_strobe_b;  // Fast-side strobe, active low.
    logic [15:0] slow_hi_out;          // Slow drive of shared lines 31..16.
    logic        slow_hi_oe;           // Slow drive enable of lines 31..16.
    logic [15:0] fast_hi_out;          // Fast drive of shared lines 31..16.
    logic        fast_hi_oe;           // Fast drive enable of lines 31..16.
    logic [13:0] fast_lo_out;          // Fast drive of shared lines 15..2.
    logic        fast_lo_oe;           // Fast drive enable of lines 15..2.
    logic [15:0] hi_in;                // Resolved level of lines 31..16.

    // The resolved level; an undriven bus reads as all ones (pull-up).
    assign hi_in = slow_hi_oe ? slow_hi_out :
                   (fast_hi_oe ? fast_hi_out : 16'hFFFF);

    modport slow (output hold_req, slow_start_ready_strobe_b, slow_hi_out,
                  slow_hi_oe, input hold_ack, fast_start_ready_strobe_b,
                  hi_in);
    modport fast (input hold_req, slow_start_ready_strobe_b, hi_in,
                  output hold_ack, fast_start_ready_strobe_b, fast_hi_out,
                  fast_hi_oe, fast_lo_out, fast_lo_oe);

endinterface : slmt_link_if

//--- verilog/slmt_fast_end.sv
// Fast-side end: arbiter, frame decoder and memory responder.
`timescale 1ns/1ps
module slmt_fast_end (
    input  wire logic        clock,        // PCI clock.
    input  wire logic        rst_b,        // Asynchronous reset, active low.
    slmt_link_if.fast        link,         // Link toward the slow side.
    input  wire logic        bus_held,     // Host and PCI buses are held.
    output logic             mem_req,      // Memory access request pulse.
    output logic             mem_write,    // Access is a write.
    output logic [31:0]      mem_addr,     // Access address.
    output logic [3:0]       mem_be,       // Active-high byte enables.
    output logic [15:0]      mem_wdata,    // Write data.
    input  wire logic        mem_done,     // Memory finished, one pulse.
    input  wire logic [15:0] mem_rdata     // Read data with mem_done.
);
    import slmt_pkg::*;

    slmt_fstate_e state;                   // Responder state.
    logic [15:0]  rdata;                   // Captured read data.

    // Acknowledge only while the buses are held for the slow side.
    wire next_ack = link.hold_req & bus_held;
    wire frame_go = (state == SLMT_F_IDLE) & link.hold_ack
                    & ~link.slow_start_ready_strobe_b;

    // ********************************************************************
    // Sequencer.
    // ********************************************************************

    // Walks the frame alongside the slow side and answers memory.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state                          <= SLMT_F_IDLE;
            link.hold_ack                  <= 1'b0;
            link.fast_start_ready_strobe_b <= 1'b1;
            link.fast_hi_oe                <= 1'b0;
            link.fast_lo_oe                <= 1'b0;
            link.fast_hi_out               <= 16'h0000;
            link.fast_lo_out               <= 14'h0000;
            mem_req                        <= 1'b0;
            mem_write                      <= 1'b0;
            mem_addr                       <= 32'h00000000;
            mem_be                         <= 4'h0;
            mem_wdata                      <= 16'h0000;
            rdata                          <= 16'h0000;
        end else begin
            link.hold_ack                  <= next_ack;
            link.fast_start_ready_strobe_b <= 1'b1;
            mem_req                        <= 1'b0;
            case (state)
                SLMT_F_IDLE: begin
                    if (frame_go) begin
                        // The strobe orders our lines released.
                        link.fast_hi_oe <= 1'b0;
                        link.fast_lo_oe <= 1'b0;
                        state           <= SLMT_F_TURN;
                    end
                end
                SLMT_F_TURN: begin
                    state <= SLMT_F_HIADR;
                end
                SLMT_F_HIADR: begin
                    mem_addr[31:16] <= link.hi_in;
                    state           <= SLMT_F_CMD;
                end
                SLMT_F_CMD: begin
                    mem_be    <= ~link.hi_in[BE_LSB +: 4];
                    mem_write <= link.hi_in[WR_BIT];
                    state     <= SLMT_F_LOADR;
                end
                SLMT_F_LOADR: begin
                    mem_addr[15:0] <= link.hi_in;
                    if (mem_write) begin
                        state <= SLMT_F_DATA;
                    end else begin
                        mem_req <= 1'b1;
                        state   <= SLMT_F_MEM;
                    end
                end
                SLMT_F_DATA: begin
                    mem_wdata <= link.hi_in;
                    mem_req   <= 1'b1;
                    state     <= SLMT_F_MEM;
                end
                SLMT_F_MEM: begin
                    // Wait phase: drive the address back on the lines.
                    link.fast_hi_oe  <= 1'b1;
                    link.fast_lo_oe  <= 1'b1;
                    link.fast_hi_out <= mem_addr[31:16];
                    link.fast_lo_out <= mem_addr[15:2];
                    if (mem_done) begin
                        rdata <= mem_rdata;
                        state <= SLMT_F_DONE;
                    end
                end
                SLMT_F_DONE: begin
                    // Last wait: read data, or the high address on a write, with the ready strobe.
                    link.fast_hi_out <= mem_write ? mem_addr[31:16] : rdata;
                    link.fast_start_ready_strobe_b <= 1'b0;
                    state <= SLMT_F_IDLE;
                end
                default: begin
                    state <= SLMT_F_IDLE;
                end
            endcase
            // Release after completion for the idle clock.
            if (state == SLMT_F_IDLE && !frame_go) begin
                link.fast_hi_oe <= 1'b0;
                link.fast_lo_oe <= 1'b0;
            end
        end
    end

endmodule // slmt_fast_end

//--- verilog/slmt_slow_end.sv
// Slow-side end: link master that frames upper-memory transfers.
`timescale 1ns/1ps

// Overview of operation
// - Raise hold request for upper-memory access.
// - Arbiter acknowledges once buses held.
// - Pulse start strobe one clock after acknowledge.
// - Two turnaround clocks, lines undriven.
// - First idle strobe releases fast lines.
// - Third clock: address high half.
// - Fourth clock: byte enables on lines 19..16.
// - Command: enables bits 0-3, write bit 4.
// - Write/read flag on line 20.
// - Fifth clock: address low half.
// - Writes add one data word clock.
// - Wait for fast ready strobe.
// - Fast side drives address while waiting.
// - Read data valid with ready strobe.
// - Only memory cycles, no I/O path.
module slmt_slow_end (
    input  wire logic        clock,      // PCI clock.
    input  wire logic        rst_b,      // Asynchronous reset, active low.
    slmt_link_if.slow        link,       // Link toward the fast side.
    input  wire logic        acc_req,    // Upper-memory access wanted (level).
    input  wire logic        acc_write,  // Access is a memory write.
    input  wire logic [31:0] acc_addr,   // Access address.
    input  wire logic [3:0]  acc_be,     // Active-high byte enables.
    input  wire logic [15:0] acc_wdata,  // Write data word.
    output logic             acc_done,   // Completion pulse.
    output logic [15:0]      acc_rdata   // Read data, valid with acc_done.
);
    import slmt_pkg::*;

    // ********************************************************************
    // Frame timing.
    // ********************************************************************

    // A frame seen from this end, one line per clock after the grant:
    //   strobe clock  start strobe low, lines undriven (idle one).
    //   next clock    lines still undriven (idle two).
    //   third clock   address bits 31..16 on the shared lines.
    //   fourth clock  command word: byte enables and write flag.
    //   fifth clock   address bits 15..0 on the shared lines.
    //   sixth clock   write data word, writes only.
    //   then          our drive is off; the far end waits for memory.
    //   last wait     far strobe low; read data stands on the lines.
    // The far end switches its drive on one clock after ours goes off,
    // so the lines see a clean turnaround in both directions.
    // Both idle clocks matter: the far end may still be driving the
    // lines when the strobe goes out, and lets go on seeing it or at the end of its own idle clock.
    // The request fields are latched when the access is taken, so the
    // user may change them while a frame is under way.
    // Only memory cycles exist: the command word has no room for any
    // other kind of cycle, and nothing here can ask for one.
    // The hold request stays up until the access has completed and the
    // user has dropped its request; a request left high starts the
    // next frame at once, after the one idle clock in the idle state.
    // The grant is taken as a level: the strobe goes out on the first
    // clock that the grant is seen high while a frame is pending.
    // There is no timeout on the ready strobe; a far end that never
    // answers leaves this end waiting in the wait state for good.
    // Byte enables travel active low on the lines, so an all-enabled
    // word shows as zeros in the low nibble of the command word.

    // ********************************************************************
    // State and latched request.
    // ********************************************************************

    slmt_state_e  state;                 // Sequencer state.
    logic [1:0]   turn_cnt;              // Turnaround clock count.
    logic         write_q;               // Latched direction of the frame.
    logic [31:0]  addr_q;                // Latched address.
    logic [3:0]   be_q;                  // Latched byte enables.
    logic [15:0]  wdata_q;               // Latched write data.

    // ********************************************************************
    // Command word and decode.
    // ********************************************************************

    // Command word: low bits byte enables (active low), then write flag.
    wire [15:0] cmd_word = {11'h000, write_q, ~be_q};
    wire        fast_rdy = ~link.fast_start_ready_strobe_b;
    wire        turn_end = (turn_cnt == TURN_LAST);

    // ********************************************************************
    // Sequencer.
    // ********************************************************************

    // Asks for the link, frames the words, then waits for ready.
    always_ff @(posedge clock or negedge rst_b) begin
        // Reset: no request, strobe high, our drive of the lines off.
        if (!rst_b) begin
            state                          <= SLMT_IDLE;
            turn_cnt                       <= 2'h0;
            write_q                        <= 1'b0;
            addr_q                         <= 32'h00000000;
            be_q                           <= 4'h0;
            wdata_q                        <= 16'h0000;
            link.hold_req                  <= 1'b0;
            link.slow_start_ready_strobe_b <= 1'b1;
            link.slow_hi_oe                <= 1'b0;
            link.slow_hi_out               <= 16'h0000;
            acc_done                       <= 1'b0;
            acc_rdata                      <= 16'h0000;
        end else begin
            // Strobe and completion are one-clock pulses by default.
            link.slow_start_ready_strobe_b <= 1'b1;
            acc_done                       <= 1'b0;
            case (state)
                // Idle: take a new access and raise the hold request,
                // or let the request fall once the user has let go.
                SLMT_IDLE: begin
                    link.slow_hi_oe <= 1'b0;
                    if (acc_req) begin
                        link.hold_req <= 1'b1;
                        write_q       <= acc_write;
                        addr_q        <= acc_addr;
                        be_q          <= acc_be;
                        wdata_q       <= acc_wdata;
                        state         <= SLMT_HOLD;
                    end else begin
                        link.hold_req <= 1'b0;
                    end
                end
                // Hold: wait for the grant, then send the start strobe
                // for exactly one clock to open the frame.
                SLMT_HOLD: begin
                    if (link.hold_ack) begin
                        // One-clock start strobe opens the frame.
                        link.slow_start_ready_strobe_b <= 1'b0;
                        turn_cnt <= 2'h0;
                        state    <= SLMT_TURN;
                    end
                end
                // Turnaround: the strobe clock counts as the first idle
                // clock; one more passes before the high address goes out.
                SLMT_TURN: begin
                    if (turn_end) begin
                        // Both idle clocks are over; drive the lines.
                        link.slow_hi_oe  <= 1'b1;
                        link.slow_hi_out <= addr_q[31:16];
                        state            <= SLMT_HIADR;
                    end else begin
                        // Lines stay undriven for the second idle clock.
                        turn_cnt <= turn_cnt + 2'h1;
                    end
                end
                // High address stands on the lines now; put the command
                // word up for the next clock.
                SLMT_HIADR: begin
                    link.slow_hi_out <= cmd_word;
                    state <= SLMT_CMD;
                end
                // Command word stands now; the low address follows it.
                SLMT_CMD: begin
                    link.slow_hi_out <= addr_q[15:0];
                    state <= SLMT_LOADR;
                end
                // Low address stands now; a write sends one data word,
                // a read lets go of the lines at once.
                SLMT_LOADR: begin
                    if (write_q) begin
                        link.slow_hi_out <= wdata_q;
                        state <= SLMT_DATA;
                    end else begin
                        link.slow_hi_oe <= 1'b0;
                        state <= SLMT_WAIT;
                    end
                end
                // Write data stands now; let go of the lines after it.
                SLMT_DATA: begin
                    link.slow_hi_oe <= 1'b0;
                    state <= SLMT_WAIT;
                end
                // Wait: the far end holds the lines until its ready
                // strobe; read data is taken on the clock that shows it.
                SLMT_WAIT: begin
                    // Fast side owns the lines until its ready.
                    if (fast_rdy) begin
                        acc_done  <= 1'b1;
                        acc_rdata <= link.hi_in;
                        state     <= SLMT_IDLE;
                    end
                end
                // Any unused state code falls back to idle.
                default: begin
                    state <= SLMT_IDLE;
                end
            endcase
        end
    end

endmodule // slmt_slow_end

//--- testbench/slmt_props.sv
// Concurrent checks on the link between the slow and fast ends.
`timescale 1ns/1ps
module slmt_props (
    input wire logic        clock,
    input wire logic        rst_b,
    input wire logic        hold_req,
    input wire logic        hold_ack,
    input wire logic        slow_start_ready_strobe_b,
    input wire logic        fast_start_ready_strobe_b,
    input wire logic [15:0] slow_hi_out,
    input wire logic        slow_hi_oe,
    input wire logic [15:0] fast_hi_out,
    input wire logic        fast_hi_oe,
    input wire logic [13:0] fast_lo_out,
    input wire logic        fast_lo_oe,
    input wire logic [15:0] hi_in
);
    // ****************************************************************
    // Frame checks, all in the one clock domain.
    // ****************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    a_strobe_pulse: assert property (
        $fell(slow_start_ready_strobe_b) |-> hold_req && hold_ack
        ##1 slow_start_ready_strobe_b)
        else $error("Slow strobe is not a granted one-clock pulse.");
    a_grant_start: assert property (
        $rose(hold_ack) |-> ##[0:2] !slow_start_ready_strobe_b)
        else $error("No start strobe after the grant.");
    a_turn_quiet: assert property (
        !slow_start_ready_strobe_b |-> !slow_hi_oe && !fast_hi_oe
        ##1 !slow_hi_oe && !fast_hi_oe)
        else $error("Shared lines driven during turnaround.");
    a_frame_words: assert property (
        !slow_start_ready_strobe_b |-> ##2 slow_hi_oe[*3])
        else $error("Slow side did not drive three frame words.");
    a_cmd_format: assert property (
        !slow_start_ready_strobe_b |-> ##3 slow_hi_out[15:5] == 11'h0)
        else $error("Command word upper bits are not zero.");
    a_no_clash: assert property (
        !(slow_hi_oe && fast_hi_oe))
        else $error("Both ends drive the shared lines.");
    a_ready_bound: assert property (
        $fell(slow_hi_oe) |-> ##[1:40] !fast_start_ready_strobe_b)
        else $error("Ready strobe did not come in time.");
    a_ready_wait: assert property (
        !fast_start_ready_strobe_b |-> !slow_hi_oe && hold_req)
        else $error("Slow side not waiting at ready.");
    a_release_idle: assert property (
        !fast_start_ready_strobe_b |=> !slow_hi_oe && !fast_hi_oe
        && fast_start_ready_strobe_b)
        else $error("Lines not released after completion.");
    a_wait_lines: assert property (
        fast_hi_oe |-> fast_lo_oe && hi_in == fast_hi_out)
        else $error("Far end does not hold all address lines.");
    a_wait_stable: assert property (
        fast_lo_oe && $past(fast_lo_oe) |-> $stable(fast_lo_out))
        else $error("Wait address changed while driven.");

    // Main scenarios: a write frame, a read frame, a completion.
    c_write: cover property (slow_hi_oe[*4]);
    c_read: cover property (!slow_hi_oe ##1 slow_hi_oe[*3] ##1 !slow_hi_oe);
    c_done: cover property ($fell(fast_start_ready_strobe_b));
endmodule // slmt_props

//--- testbench/slow_link_master_transfer_tb.sv
// Self-checking bench joining both ends of the slow link.
`timescale 1ns/1ps
module slow_link_master_transfer_tb;
    import slmt_pkg::*;
    logic        clock     = 1'b0;  // Link clock, 40 ns period.
    logic        rst_b     = 1'b0;  // Reset, active low.
    logic        acc_req   = 1'b0;  // Access request to the slow end.
    logic        acc_write = 1'b0;  // Access direction.
    logic [31:0] acc_addr  = '0;    // Access address.
    logic [3:0]  acc_be    = '0;    // Access byte enables.
    logic [15:0] acc_wdata = '0;    // Access write data.
    logic        acc_done;          // Completion from the slow end.
    logic [15:0] acc_rdata;         // Read data from the slow end.
    logic        bus_held  = 1'b0;  // Buses held toward the arbiter.
    logic        mem_req, mem_write; // Memory request and direction.
    logic [31:0] mem_addr;          // Memory address.
    logic [3:0]  mem_be;            // Memory byte enables.
    logic [15:0] mem_wdata;         // Memory write data.
    logic        mem_done  = 1'b0;  // Memory completion pulse.
    logic [15:0] mem_rdata = '0;    // Memory read data.
    int          errors    = 0;     // Mismatches seen.
    int          n_checks  = 0;     // Comparisons made.
    logic [15:0] mdl [logic [31:0]]; // Reference memory contents.
    logic [31:0] a;                  // Address shared by a write/read pair.

    // The clock toggles every half period.
    always #20 clock = ~clock;

    slmt_link_if link ();
    slmt_slow_end u_slmt_slow_end (.clock, .rst_b, .link, .acc_req,
        .acc_write, .acc_addr, .acc_be, .acc_wdata, .acc_done, .acc_rdata);
    slmt_fast_end u_slmt_fast_end (.clock, .rst_b, .link, .bus_held,
        .mem_req, .mem_write, .mem_addr, .mem_be, .mem_wdata, .mem_done,
        .mem_rdata);
    slmt_props u_props (.clock(clock), .rst_b(rst_b),
        .hold_req(link.hold_req), .hold_ack(link.hold_ack),
        .slow_start_ready_strobe_b(link.slow_start_ready_strobe_b),
        .fast_start_ready_strobe_b(link.fast_start_ready_strobe_b),
        .slow_hi_out(link.slow_hi_out), .slow_hi_oe(link.slow_hi_oe),
        .fast_hi_out(link.fast_hi_out), .fast_hi_oe(link.fast_hi_oe),
        .fast_lo_out(link.fast_lo_out), .fast_lo_oe(link.fast_lo_oe),
        .hi_in(link.hi_in));

    // ****************************************************************
    // Helpers: step, compare, bounded wait and the closing report.
    // ****************************************************************
    task automatic step();
        @(posedge clock);
        #1;
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] e, g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask

    function automatic logic sig(input int k);
        case (k)
            0: return link.hold_req;
            1: return link.slow_start_ready_strobe_b;
            2: return mem_req;
            default: return acc_done;
        endcase
    endfunction

    // A wait that runs out counts a mismatch and ends the run.
    task automatic wt(input int k, input logic v);
        int n;
        for (n = 0; n < 60 && sig(k) !== v; n++) step();
        if (sig(k) !== v) begin
            errors++;
            $display("MISMATCH wait %0d exp %b got %b", k, v, sig(k));
            print_verdict();
        end
    endtask

    // One transfer; the bench holds the buses and plays memory of the fast end.
    task automatic xfer(input logic w, input logic [31:0] ad,
                        input logic [3:0] be, input logic [15:0] d);
        logic [15:0] rd;
        rd = w ? d : (mdl.exists(ad) ? mdl[ad] : 16'($urandom));
        mdl[ad] = rd;
        acc_req = 1'b1;
        acc_write = w;
        acc_addr = ad;
        acc_be = be;
        acc_wdata = d;
        wt(0, 1'b1);
        repeat ($urandom % 3) step();
        bus_held = 1'b1;
        wt(1, 1'b0);
        step();
        chk("turn oe", 0, {link.slow_hi_oe, link.fast_hi_oe});
        step();
        chk("hi addr", ad[31:16], link.hi_in);
        step();
        chk("cmd", {11'h0, w, ~be}, link.hi_in);
        step();
        chk("lo addr", ad[15:0], link.hi_in);
        if (w) begin
            step();
            chk("wdata", d, link.hi_in);
        end
        wt(2, 1'b1);
        chk("mem", {w, be, ad}, {mem_write, mem_be, mem_addr});
        if (w) chk("mem wdata", d, mem_wdata);
        step();
        chk("wait oe", 2'h3, {link.fast_hi_oe, link.fast_lo_oe});
        chk("wait adr", ad[31:2], {link.hi_in, link.fast_lo_out});
        repeat ($urandom % 6) step();
        mem_done = 1'b1;
        mem_rdata = rd;
        step();
        mem_done = 1'b0;
        mem_rdata = ~rd;
        if (link.fast_start_ready_strobe_b) step();
        if (!w) chk("rd lines", rd, link.hi_in);
        wt(3, 1'b1);
        chk("rdata", w ? ad[31:16] : rd, acc_rdata);
        acc_req = 1'b0;
        wt(0, 1'b0);
        bus_held = 1'b0;
        step();
    endtask

    // ****************************************************************
    // Main sequence: back-to-back write/read pairs over all enables.
    // ****************************************************************
    initial begin
        int i;
        void'($urandom(17));
        repeat (5) @(posedge clock);
        #1 rst_b = 1'b1;
        for (i = 0; i < 16; i++) begin
            if (!i[0]) a = (i == 0) ? 32'hFFFFFFFF : $urandom;
            xfer(!i[0], a, i[3:0], 16'($urandom));
        end
        print_verdict();
    end
endmodule // slow_link_master_transfer_tb
